// ===== hw/etilir_pkg.sv
// Constants and shared helpers for the edge-triggered input latch interrupt block
// Behaviour
// - Request and gate lines double as plain inputs
// - Request edge selectable rising or falling
// - Reset gives rising edge, latching off
// - Latch mode captures input port on edge
// - Qualifying edge sets pending flag bit 17
// - PCI interrupt only if enable bit 12 set
// - Latching holds until non-latching setting written
// - Unacknowledged latch is overwritten by next edge
// - Request and gate bits excluded from latch
// - Edges ignored while pending, except by the latch; first sets missed
// - Rise/fall flags recorded; software clears all four
// - One shared interrupt, no per-bit sources
// - Gate high blocks interrupt, latch and pending
// - Group bit 5 enables latch, bit 6 edge
// - Latch or interrupt edge match sets pending
package etilir_pkg;
    localparam int PORT_W = 8;
    localparam int REQ_BIT = 6;
    localparam int GATE_BIT = 7;
    localparam logic POL_RISING = 1'b0;
    localparam logic POL_FALLING = 1'b1;
    localparam logic [PORT_W-1:0] LATCH_RST = 8'h00;
    localparam logic [PORT_W-1:0] LATCH_MASK = 8'h3f;

    // True when the selected edge matches the observed one
    function automatic logic etilir_edge_match(input logic pol, input logic rise, input logic fall);
        etilir_edge_match = (pol == POL_RISING) ? rise : fall;
    endfunction : etilir_edge_match
endpackage : etilir_pkg

// ===== hw/etilir_sync.sv
// Two-flop synchroniser and edge detector for one input line
`timescale 1ns/10ps
module etilir_sync
    import etilir_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Line
    input wire logic line_i,
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // First flop feeds only the second
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= line_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Edges come from settled stages, so each edge is seen once
    assign level_o = sync_q;
    assign rise_o = sync_q & ~prev_q;
    assign fall_o = ~sync_q & prev_q;
endmodule : etilir_sync

// ===== hw/etilir_latch.sv
// Input data latch with request and gate bits masked out
`timescale 1ns/10ps
module etilir_latch
    import etilir_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Capture
    input wire logic capture_i,
    input wire logic [PORT_W-1:0] port_i,
    output logic [PORT_W-1:0] data_o
);
    logic [PORT_W-1:0] data_q;

    // Newer capture simply overwrites, no acknowledge needed
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            data_q <= LATCH_RST;
        end else if (capture_i) begin
            data_q <= port_i & LATCH_MASK;
        end
    end

    assign data_o = data_q;
endmodule : etilir_latch

// ===== hw/etilir_top.sv
// External interrupt and input latch control logic
`timescale 1ns/10ps
module etilir_top
    import etilir_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Field input port, request on bit 6, gate on bit 7
    input wire logic [PORT_W-1:0] port_i,
    // Configuration
    input wire logic irq_en_i,
    input wire logic irq_pol_i,
    input wire logic latch_en_i,
    input wire logic latch_pol_i,
    // Software clears, one-cycle pulses
    input wire logic clr_pending_i,
    input wire logic clr_missed_i,
    input wire logic clr_edges_i,
    // Status and data
    output logic [PORT_W-1:0] port_data_o,
    output logic [PORT_W-1:0] latch_data_o,
    output logic pending_o,
    output logic missed_o,
    output logic rise_flag_o,
    output logic fall_flag_o,
    output logic pci_irq_o
);
    logic req_lvl;
    logic req_rise;
    logic req_fall;
    logic gate_lvl;
    logic irq_hit;
    logic latch_hit;
    logic qualify;
    logic capture;
    logic pending_q;
    logic missed_q;
    logic rise_q;
    logic fall_q;
    logic irq_q;
    logic [PORT_W-1:0] port_q;

    // Request line synchroniser
    etilir_sync u_req (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .line_i(port_i[REQ_BIT]),
        .level_o(req_lvl),
        .rise_o(req_rise),
        .fall_o(req_fall)
    );

    // Gate line synchroniser; its edges are not used
    etilir_sync u_gate (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .line_i(port_i[GATE_BIT]),
        .level_o(gate_lvl),
        .rise_o(),
        .fall_o()
    );

    // Edge qualification; gate high blocks everything
    assign irq_hit = irq_en_i & etilir_edge_match(irq_pol_i, req_rise, req_fall);
    assign latch_hit = latch_en_i & etilir_edge_match(latch_pol_i, req_rise, req_fall);
    assign qualify = ~gate_lvl & (irq_hit | latch_hit);
    // Latch follows its own edge even when pending is already set
    assign capture = ~gate_lvl & latch_hit;

    etilir_latch u_latch (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .capture_i(capture),
        .port_i(port_i),
        .data_o(latch_data_o)
    );

    // Pending flag, set wins over clear
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pending_q <= 1'b0;
        end else if (qualify) begin
            pending_q <= 1'b1;
        end else if (clr_pending_i) begin
            pending_q <= 1'b0;
        end
    end

    // Missed flag: only first ignored edge while pending
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            missed_q <= 1'b0;
        end else if (qualify && pending_q && !missed_q) begin
            missed_q <= 1'b1;
        end else if (clr_missed_i) begin
            missed_q <= 1'b0;
        end
    end

    // Edge type flags, recorded on the accepted edge only
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            if (qualify && !pending_q && req_rise) begin
                rise_q <= 1'b1;
            end else if (clr_edges_i) begin
                rise_q <= 1'b0;
            end
            if (qualify && !pending_q && req_fall) begin
                fall_q <= 1'b1;
            end else if (clr_edges_i) begin
                fall_q <= 1'b0;
            end
        end
    end

    // Single shared interrupt; raised only by an enabled edge, held until pending clears or irq_en_i drops.
    // The clear pulse drops it on that edge even when a qualifying edge keeps pending set, so it never outlives the flag.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            irq_q <= 1'b0;
        end else if (qualify && irq_hit && !pending_q) begin
            irq_q <= 1'b1;
        end else if (!pending_q || !irq_en_i || clr_pending_i) begin
            irq_q <= 1'b0;
        end
    end

    // Plain registered readback of all lines
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            port_q <= LATCH_RST;
        end else begin
            port_q <= port_i;
        end
    end

    assign port_data_o = port_q;
    assign pending_o = pending_q;
    assign missed_o = missed_q;
    assign rise_flag_o = rise_q;
    assign fall_flag_o = fall_q;
    assign pci_irq_o = irq_q;
    // Reset defaults (rising, no latch) are the software's port values at reset
endmodule : etilir_top

// ===== verification/etilir_checker.sv
// Port checker for the input latch interrupt block
`timescale 1ns/10ps
module etilir_checker (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Watched ports
    input wire logic [7:0] port_i,
    input wire logic irq_en_i,
    input wire logic latch_en_i,
    input wire logic clr_pending_i,
    input wire logic [7:0] latch_data_o,
    input wire logic pending_o,
    input wire logic missed_o,
    input wire logic rise_flag_o,
    input wire logic pci_irq_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    // No request edge may be in flight through the synchroniser
    sequence req_quiet;
        $stable(port_i[6])[*4];
    endsequence
    // Gate held high long enough to be seen past the synchroniser
    sequence gate_shut;
        port_i[7][*5];
    endsequence
    AST_IRQ_PEND: assert property (pci_irq_o |-> pending_o) else $error("irq alone");
    AST_IRQ_EN: assert property (!irq_en_i [*2] |-> !pci_irq_o) else $error("irq off");
    AST_GATE: assert property (gate_shut |-> !$rose(pending_o)) else $error("gated");
    AST_MISS: assert property ($rose(missed_o) |-> $past(pending_o)) else $error("missed");
    AST_MASK: assert property (latch_data_o[7:6] == 2'h0) else $error("mask");
    AST_HOLD: assert property (!latch_en_i [*4] |-> $stable(latch_data_o)) else $error("hold");
    AST_CLR: assert property (req_quiet ##0 clr_pending_i |=> !pending_o && !pci_irq_o) else $error("clr");
    AST_FLAG: assert property ($rose(rise_flag_o) |-> $rose(pending_o)) else $error("flag");
endmodule : etilir_checker
bind etilir_top etilir_checker u_chk (.sys_clk_i, .sys_rst_i, .port_i, .irq_en_i, .latch_en_i,
    .clr_pending_i, .latch_data_o, .pending_o, .missed_o, .rise_flag_o, .pci_irq_o);

// ===== verification/etilir_field_src.sv
// Field input source model for the isolated port lines
`timescale 1ns/10ps
module etilir_field_src (
    // Clock
    input wire logic sys_clk_i,
    // Wanted line levels
    input wire logic [5:0] data_i,
    input wire logic ext_irq_gate_n_i,
    input wire logic input_line_six_i,
    // Field port
    output logic [7:0] port_o = 8'h00
);
    // Lines move just after each sys_clk_i edge, in step with the DUT's sampling clock
    always @(posedge sys_clk_i) begin
        port_o <= {ext_irq_gate_n_i, input_line_six_i, data_i};
    end
endmodule : etilir_field_src

// ===== verification/test_etilir_top.sv
// Self-checking bench for the input latch interrupt block
`timescale 1ns/10ps
module test_etilir_top;
    logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, gate_n = 1'b0, req = 1'b0;
    logic irq_en_i = 1'b0, irq_pol_i = 1'b0, latch_en_i = 1'b0, latch_pol_i = 1'b0;
    logic clr_pending_i = 1'b0, clr_missed_i = 1'b0, clr_edges_i = 1'b0;
    logic [5:0] data = 6'h00;
    logic [7:0] port_i, port_data_o, latch_data_o, exp_latch = 8'h00;
    logic pending_o, missed_o, rise_flag_o, fall_flag_o, pci_irq_o;
    int n_errors = 0, comparisons = 0, cycles = 0;
    // Clock and hang ceiling
    always #2.5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            give_verdict();
        end
    end
    etilir_field_src u_src (.sys_clk_i, .data_i(data), .ext_irq_gate_n_i(gate_n), .input_line_six_i(req),
        .port_o(port_i));
    etilir_top u_dut (.sys_clk_i, .sys_rst_i, .port_i, .irq_en_i, .irq_pol_i, .latch_en_i, .latch_pol_i,
        .clr_pending_i, .clr_missed_i, .clr_edges_i, .port_data_o, .latch_data_o, .pending_o, .missed_o,
        .rise_flag_o, .fall_flag_o, .pci_irq_o);
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    // Toggle the request line; a zero polarity bit means rising edge
    task automatic pulse_req();
        logic rise, irq, lat, pend;
        rise = !req;
        irq = !gate_n && irq_en_i && (irq_pol_i ^ rise);
        lat = !gate_n && latch_en_i && (latch_pol_i ^ rise);
        pend = irq || lat;
        if (lat) exp_latch = {2'h0, data};
        req <= rise;
        repeat (6) @(posedge sys_clk_i);
        check("status", {4'h0, pci_irq_o, pending_o, rise_flag_o, fall_flag_o},
            {4'h0, irq, pend, pend && rise, pend && !rise});
        check("latch", latch_data_o, exp_latch);
        check("port", port_data_o, {gate_n, req, data});
    endtask : pulse_req
    // Software end of service: all four flags cleared together
    task automatic clear_all();
        {clr_pending_i, clr_missed_i, clr_edges_i} <= 3'h7;
        @(posedge sys_clk_i);
        {clr_pending_i, clr_missed_i, clr_edges_i} <= 3'h0;
        repeat (2) @(posedge sys_clk_i);
        check("clear", {3'h0, pending_o, missed_o, rise_flag_o, fall_flag_o, pci_irq_o}, 8'h00);
    endtask : clear_all
    initial begin
        void'($urandom(29));
        repeat (2) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge sys_clk_i);
        pulse_req();
        // Random settings, gate shut one time in five
        for (int i = 0; i < 60; i++) begin
            {irq_en_i, irq_pol_i, latch_en_i, latch_pol_i} <= 4'($urandom);
            data <= 6'($urandom);
            gate_n <= ($urandom % 5) == 0;
            repeat (4) @(posedge sys_clk_i);
            pulse_req();
            clear_all();
        end
        // Interrupt on rise, latch on fall: the fall lands while pending
        {irq_en_i, irq_pol_i, latch_en_i, latch_pol_i} <= 4'hb;
        gate_n <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        if (req) begin
            pulse_req();
            clear_all();
        end
        pulse_req();
        data <= 6'h2a;
        req <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
        check("missed", {missed_o, latch_data_o[6:0]}, 8'haa);
        clear_all();
        give_verdict();
    end
endmodule : test_etilir_top
